// ### common/crm_defs.vh
// Constants for the core register file and data memory decoder.
// Operation
// - Status bit 7 shows interrupt in service, read only, clears at reset.
// - Status bit 6 is the master interrupt enable, writable, resets to zero.
// - Status bits 5 to 3 always read zero.
// - Counter high byte bits 15 to 13 read zero; the rest writable.
// - Program counter is 13 bits, linear 8k words.
// - Only the first 6k program words are backed by storage.
// - Bank select low four bits writable, pick bank at 0x80-0xFF; upper zero.
// - Table base bits 7 and 6 ignored; rest form table address; reset zero.
// - Data addresses 0x00-0x7F are the same for every bank value.
// - Locations 0x00-0x17 are the 24 core and peripheral registers.
// - Locations 0x18-0x3F are 40 direct RAM bytes, unpaged.
// - Locations 0x40-0x7F reachable only by paged moves or indirect access.
// - Locations 0x80-0xFF reachable only by paged moves or indirect access.
// - Rarely used peripheral configuration sits in the paged window from 0x0D0.
// - Bank select supplies the top four bits of the 12-bit paged address.
// - Table read pointer bit 0 picks low byte when 0, high byte when 1.
`ifndef CRM_DEFS_VH
`define CRM_DEFS_VH
`define CRM_A_ACC 8'h00
`define CRM_A_STATUS 8'h01
`define CRM_A_IPLO 8'h02
`define CRM_A_IPHI 8'h03
`define CRM_A_BANK 8'h04
`define CRM_A_TBASE 8'h05
`define CRM_A_PERIPH_LAST 8'h17
`define CRM_A_RAM_FIRST 8'h18
`define CRM_A_RAM_LAST 8'h3f
`define CRM_A_IND_FIRST 8'h40
`define CRM_A_PAGED_FIRST 8'h80
`define CRM_A_PCFG_FIRST 8'hd0
`define CRM_A_BRAM_LAST 8'hcf
`define CRM_PAGES_WITH_RAM 4'h1
`define CRM_ST_SERV 7
`define CRM_ST_MIE 6
`define CRM_ST_FLAGS_MSB 2
`define CRM_PC_HI_MASK 8'h1f
`define CRM_BANK_MASK 8'h0f
`define CRM_TBASE_MASK 8'h3f
`define CRM_PC_WORDS_BACKED 13'h1800
`define CRM_RST8 8'h00
// Avalon word offsets, the data address sits at byte address times four.
`define CRM_BUS_AW 12
`define CRM_CTRL_WORD 10'h3ff
`endif

// ### verilog/crm_ram.v
// Single port byte array used for the unpaged and banked RAM.
`timescale 1ns/1ps
`default_nettype none
module crm_ram #(
  parameter AW = 10
) (
  input wire clk,
  input wire we,
  input wire [AW-1:0] addr,
  input wire [7:0] wdata,
  output reg [7:0] rdata
);
  reg [7:0] mem [0:(1<<AW)-1];
  always @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule
`default_nettype wire

// ### verilog/crm_core_regs.v
// Core registers and data memory decoder behind an Avalon-MM slave.
`timescale 1ns/1ps
`default_nettype none
`include "crm_defs.vh"
module crm_core_regs (
  input wire clk,
  input wire rst,
  input wire [11:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire direct_mode,
  input wire irq_enter,
  input wire irq_return,
  input wire [12:0] table_ptr_word,
  output wire [12:0] table_prog_addr,
  output wire table_high_byte,
  output wire table_addr_valid,
  output wire [12:0] program_counter,
  output wire [7:0] periph_addr,
  output wire periph_wr,
  output wire periph_rd,
  output wire [7:0] periph_wdata,
  input wire [7:0] periph_rdata,
  output wire master_irq_enable,
  output wire irq_servicing_flag
);
  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_DONE = 3'b100;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [7:0] accumulator_reg;
  reg irq_serv;
  reg irq_en;
  reg [2:0] flags;
  reg [7:0] instr_pointer_low;
  reg [7:0] instr_pointer_high;
  reg [7:0] bank_select;
  reg [7:0] table_read_base;
  reg [7:0] rd_hold;
  reg sel_ram_q;
  reg sel_per_q;
  reg mode_q1;
  reg mode_q2;

  wire [7:0] a_lo = avs_address[7:0];
  wire ctl_word = avs_address[9:0] == `CRM_CTRL_WORD;
  wire req = avs_read | avs_write;
  // A write lands only at the edge where waitrequest is seen low.
  wire wr_now = avs_write && state == ST_DONE && avs_byteenable[0];
  wire [7:0] wd = avs_writedata[7:0];

  // A paged access carries the bank in the top nibble of the address.
  function [11:0] crm_full_addr;
    input [7:0] lo;
    input [7:0] bank;
    begin
      if (lo >= `CRM_A_PAGED_FIRST) begin
        crm_full_addr = {bank[3:0], lo};
      end else begin
        crm_full_addr = {4'h0, lo};
      end
    end
  endfunction

  // Classify a data address; returns ram, peripheral and valid flags.
  function [2:0] crm_decode;
    input [7:0] lo;
    input [7:0] bank;
    input direct;
    reg ram;
    reg per;
    begin
      ram = 1'b0;
      per = 1'b0;
      if (lo <= `CRM_A_PERIPH_LAST) begin
        per = lo > `CRM_A_TBASE;
      end else if (lo <= `CRM_A_RAM_LAST) begin
        ram = 1'b1;
      end else if (lo < `CRM_A_PAGED_FIRST) begin
        ram = !direct;
      end else if (!direct) begin
        if (lo <= `CRM_A_BRAM_LAST) begin
          ram = bank[3:0] <= `CRM_PAGES_WITH_RAM;
        end else begin
          per = 1'b1;
        end
      end
      crm_decode = {ram, per, ram | per};
    end
  endfunction

  wire [2:0] dec = crm_decode(a_lo, bank_select, mode_q2);
  wire [11:0] full = crm_full_addr(a_lo, bank_select);
  // RAM index: 0x18-0x7F unpaged, then 0x80-0xCF in banks 0 and 1.
  wire [9:0] ram_idx = full[7] ? {1'b0, full[8], full[7:0]} + 10'h080
                                : {2'b00, full[7:0]};
  wire [7:0] ram_q;

  crm_ram #(.AW(10)) u_ram (
    .clk(clk),
    .we(wr_now && !ctl_word && dec[2]),
    .addr(ram_idx),
    .wdata(wd),
    .rdata(ram_q)
  );

  // Read and write complete after two wait cycles so RAM data can settle.
  assign avs_waitrequest = req && state != ST_DONE;

  always @* begin
    case (state)
      ST_IDLE: next_state = req ? ST_WAIT : ST_IDLE;
      ST_WAIT: next_state = ST_DONE;
      ST_DONE: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  // The mode pin comes from outside, so it is synchronised first.
  always @(posedge clk) begin
    if (rst) begin
      mode_q1 <= 1'b0;
      mode_q2 <= 1'b0;
    end else begin
      mode_q1 <= direct_mode;
      mode_q2 <= mode_q1;
    end
  end

  wire core_wr = wr_now && !ctl_word;

  always @(posedge clk) begin
    if (rst) begin
      state <= ST_IDLE;
      accumulator_reg <= `CRM_RST8;
      irq_serv <= 1'b0;
      irq_en <= 1'b0;
      flags <= 3'b000;
      instr_pointer_low <= `CRM_RST8;
      instr_pointer_high <= `CRM_RST8;
      bank_select <= `CRM_RST8;
      table_read_base <= `CRM_RST8;
    end else begin
      state <= next_state;
      // Entry wins over a return in the same cycle so no service is lost.
      if (irq_enter) begin
        irq_serv <= 1'b1;
      end else if (irq_return) begin
        irq_serv <= 1'b0;
      end
      if (core_wr) begin
        case (a_lo)
          `CRM_A_ACC: accumulator_reg <= wd;
          `CRM_A_STATUS: begin
            irq_en <= wd[`CRM_ST_MIE];
            flags <= wd[`CRM_ST_FLAGS_MSB:0];
          end
          `CRM_A_IPLO: instr_pointer_low <= wd;
          `CRM_A_IPHI: instr_pointer_high <= wd & `CRM_PC_HI_MASK;
          `CRM_A_BANK: bank_select <= wd & `CRM_BANK_MASK;
          `CRM_A_TBASE: table_read_base <= wd & `CRM_TBASE_MASK;
          default: accumulator_reg <= accumulator_reg;
        endcase
      end
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      rd_hold <= `CRM_RST8;
      sel_ram_q <= 1'b0;
      sel_per_q <= 1'b0;
    end else if (state == ST_IDLE && req) begin
      sel_ram_q <= dec[2] && !ctl_word;
      sel_per_q <= dec[1] && !ctl_word;
      if (ctl_word) begin
        rd_hold <= {7'h00, mode_q2};
      end else begin
        case (a_lo)
          `CRM_A_ACC: rd_hold <= accumulator_reg;
          `CRM_A_STATUS: rd_hold <= {irq_serv, irq_en, 3'b000, flags};
          `CRM_A_IPLO: rd_hold <= instr_pointer_low;
          `CRM_A_IPHI: rd_hold <= instr_pointer_high;
          `CRM_A_BANK: rd_hold <= bank_select;
          `CRM_A_TBASE: rd_hold <= table_read_base;
          // Peripheral data is only valid while its read strobe stands.
          default: rd_hold <= dec[1] ? periph_rdata : `CRM_RST8;
        endcase
      end
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (state == ST_WAIT) begin
      if (sel_ram_q) begin
        avs_readdata <= {24'h000000, ram_q};
      end else if (sel_per_q) begin
        avs_readdata <= {24'h000000, rd_hold};
      end else begin
        avs_readdata <= {24'h000000, rd_hold};
      end
    end
  end

  assign periph_addr = a_lo;
  assign periph_wr = core_wr && dec[1];
  assign periph_rd = avs_read && state == ST_IDLE && dec[1] && !ctl_word;
  assign periph_wdata = wd;

  assign program_counter = {instr_pointer_high[4:0], instr_pointer_low};
  assign table_prog_addr = {table_read_base[5:0], table_ptr_word[7:1]};
  assign table_high_byte = table_ptr_word[0];
  assign table_addr_valid = table_prog_addr < `CRM_PC_WORDS_BACKED;
  assign master_irq_enable = irq_en;
  assign irq_servicing_flag = irq_serv;
endmodule
`default_nettype wire

// ### tb/crm_periph_model.sv
// Behavioural model of the peripheral registers behind the decoder.
`timescale 1ns/1ps
`default_nettype none
module crm_periph_model (
  input wire logic clk,
  input wire logic [7:0] periph_addr,
  input wire logic periph_wr,
  input wire logic periph_rd,
  input wire logic [7:0] periph_wdata,
  output logic [7:0] periph_rdata
);
  logic [7:0] mem [0:255];
  always @(posedge clk) begin
    if (periph_wr) begin
      mem[periph_addr] <= periph_wdata;
    end
  end
  // Outside a read strobe the bus is not driven, so show the inverse.
  assign periph_rdata = periph_rd ? mem[periph_addr] : ~mem[periph_addr];
endmodule
`default_nettype wire

// ### tb/crm_core_regs_assertions.sv
// Concurrent checks on the ports of the core register block.
`timescale 1ns/1ps
`default_nettype none
module crm_core_regs_assertions (
  input wire clk,
  input wire rst,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire irq_enter,
  input wire irq_return,
  input wire irq_servicing_flag,
  input wire master_irq_enable,
  input wire [12:0] table_ptr_word,
  input wire [12:0] table_prog_addr,
  input wire table_high_byte,
  input wire table_addr_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_serv_set: assert property (irq_enter |=> irq_servicing_flag)
    else $error("servicing flag not set");
  a_serv_clear: assert property (irq_return && !irq_enter |=>
    !irq_servicing_flag) else $error("servicing flag not cleared");
  a_serv_hold: assert property (!irq_enter && !irq_return |=>
    $stable(irq_servicing_flag)) else $error("servicing flag moved");
  a_enable_hold: assert property (!avs_write |=>
    $stable(master_irq_enable)) else $error("enable moved");
  a_reset_clear: assert property ($fell(rst) |->
    !master_irq_enable && !irq_servicing_flag) else $error("not cleared");
  a_table_map: assert property (table_high_byte == table_ptr_word[0] &&
    table_prog_addr[6:0] == table_ptr_word[7:1]) else $error("table map");
  a_table_valid: assert property (table_addr_valid ==
    (table_prog_addr < 13'h1800)) else $error("table valid wrong");
  a_bus_answer: assert property ($rose(avs_read) |->
    avs_waitrequest [*2] ##1 !avs_waitrequest) else $error("late answer");
  c_irq: cover property (irq_enter);
  c_write: cover property (avs_write && !avs_waitrequest);
  c_table: cover property (table_high_byte && !table_addr_valid);
endmodule
bind crm_core_regs crm_core_regs_assertions crm_core_regs_assertions_inst (
  .clk(clk), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .irq_enter(irq_enter),
  .irq_return(irq_return), .irq_servicing_flag(irq_servicing_flag),
  .master_irq_enable(master_irq_enable), .table_ptr_word(table_ptr_word),
  .table_prog_addr(table_prog_addr), .table_high_byte(table_high_byte),
  .table_addr_valid(table_addr_valid));
`default_nettype wire

// ### tb/test_core_regs_and_data_memory_map.sv
// Self-checking testbench for the core register file and decoder.
`timescale 1ns/1ps
`default_nettype none
module test_core_regs_and_data_memory_map;
  logic clk, rst, avs_read, avs_write, wreq, dm, ie, ir, hi, vl, pw, pr, mie;
  logic sv;
  logic [11:0] aa;
  logic [31:0] wd, rdat;
  logic [12:0] ptr, ta, pc;
  logic [7:0] pa, pwd, prd, q;
  int num_errors = 0;
  int total_checks = 0;
  crm_core_regs crm_core_regs_inst (.clk(clk), .rst(rst), .avs_address(aa),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(wd),
    .avs_byteenable(4'hf), .avs_readdata(rdat), .avs_waitrequest(wreq),
    .direct_mode(dm), .irq_enter(ie), .irq_return(ir), .table_ptr_word(ptr),
    .table_prog_addr(ta), .table_high_byte(hi), .table_addr_valid(vl),
    .program_counter(pc), .periph_addr(pa), .periph_wr(pw), .periph_rd(pr),
    .periph_wdata(pwd), .periph_rdata(prd), .master_irq_enable(mie),
    .irq_servicing_flag(sv));
  crm_periph_model crm_periph_model_inst (.clk(clk), .periph_addr(pa),
    .periph_wr(pw), .periph_rd(pr), .periph_wdata(pwd), .periph_rdata(prd));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Two idle edges between requests keep clear of the decoder's turnaround.
  task automatic acc(input logic [11:0] a, input logic w, input logic [7:0] d);
    repeat (2) @(posedge clk);
    aa <= a;
    avs_write <= w;
    avs_read <= !w;
    wd <= {24'h0, d};
    @(negedge clk);
    while (wreq !== 1'b0) @(negedge clk);
    q = rdat[7:0];
    chk(rdat[31:8], 24'h0);
    @(posedge clk);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    acc(a, 1'b1, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    acc(a, 1'b0, 8'h00);
    chk(q, e);
  endtask
  task automatic pulse(input logic enter);
    @(posedge clk);
    ie <= enter;
    ir <= !enter;
    @(posedge clk);
    ie <= 1'b0;
    ir <= 1'b0;
  endtask
  task t_reset;
    rd(12'h001, 8'h00);
    rd(12'h003, 8'h00);
    rd(12'h005, 8'h00);
    $display("reset test done");
  endtask
  task t_status;
    wr(12'h001, 8'hff);
    rd(12'h001, 8'h47);
    chk(mie, 1'b1);
    pulse(1'b1);
    rd(12'h001, 8'hc7);
    pulse(1'b0);
    wr(12'h001, 8'h00);
    rd(12'h001, 8'h00);
    $display("status test done");
  endtask
  task t_regs;
    wr(12'h000, 8'ha5);
    rd(12'h000, 8'ha5);
    wr(12'h002, 8'h34);
    wr(12'h003, 8'hff);
    rd(12'h003, 8'h1f);
    chk(pc, 13'h1f34);
    wr(12'h004, 8'hff);
    rd(12'h004, 8'h0f);
    wr(12'h00a, 8'h5a);
    rd(12'h00a, 8'h5a);
    rd(12'h0a0, 8'h00);
    $display("register test done");
  endtask
  task t_paging;
    wr(12'h004, 8'h00);
    wr(12'h080, 8'h11);
    wr(12'h0d0, 8'h66);
    wr(12'h004, 8'h01);
    wr(12'h080, 8'h22);
    wr(12'h040, 8'h33);
    wr(12'h018, 8'h44);
    wr(12'h004, 8'h00);
    rd(12'h080, 8'h11);
    rd(12'h0d0, 8'h66);
    rd(12'h040, 8'h33);
    rd(12'h018, 8'h44);
    wr(12'h004, 8'h05);
    wr(12'h080, 8'h55);
    rd(12'h080, 8'h00);
    wr(12'h004, 8'h01);
    rd(12'h080, 8'h22);
    dm <= 1'b1;
    rd(12'h040, 8'h00);
    rd(12'h018, 8'h44);
    dm <= 1'b0;
    $display("paging test done");
  endtask
  task t_table;
    wr(12'h005, 8'hff);
    rd(12'h005, 8'h3f);
    ptr <= 13'h00ff;
    @(negedge clk);
    chk(ta, 13'h1fff);
    chk(hi, 1'b1);
    chk(vl, 1'b0);
    wr(12'h005, 8'h2f);
    ptr <= 13'h00fe;
    @(negedge clk);
    chk(ta, 13'h17ff);
    chk(hi, 1'b0);
    chk(vl, 1'b1);
    $display("table test done");
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    {avs_read, avs_write, dm, ie, ir} = 5'h00;
    aa = 12'h000;
    wd = 32'h0;
    ptr = 13'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_status;
    t_regs;
    t_paging;
    t_table;
    conclude;
  end
  initial begin
    repeat (8000) @(posedge clk);
    num_errors++;
    conclude;
  end
endmodule
`default_nettype wire
